// [brake_cal_pkg.sv]
package brake_cal_pkg;

   // ********************************************************
   // bus and field widths
   // ********************************************************
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 8;
   localparam int SAMPLE_W = 8;
   localparam int LEN_W    = 8;
   localparam int STEP_W   = 8;

   // ********************************************************
   // register offsets
   // ********************************************************
   localparam logic [7:0] OFS_BRAKE = 8'h1D;
   localparam logic [7:0] OFS_FS    = 8'h1F;
   localparam logic [7:0] OFS_OD    = 8'h20;
   localparam logic [7:0] OFS_COMP  = 8'h21;
   localparam logic [7:0] OFS_FB    = 8'h22;

   // ********************************************************
   // reset values
   // ********************************************************
   localparam logic [7:0] RST_BRAKE = 8'h00;
   localparam logic [7:0] RST_FS    = 8'h3F;
   localparam logic [7:0] RST_OD    = 8'h89;
   localparam logic [7:0] RST_COMP  = 8'h0D;
   localparam logic [7:0] RST_FB    = 8'h6D;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ********************************************************
   // loss compensation scaling: (impedance * level) >> shift
   // ********************************************************
   localparam int COMP_SHIFT = 8;

endpackage

// [brake_time_calc.sv]
`timescale 1ns/1ps
module brake_time_calc #(
   parameter int LEN_W  = 8,
   parameter int OFS_W  = 8,
   parameter int STEP_W = 8,
   parameter int MS_W   = LEN_W + 1 + STEP_W
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    valid_i,
   input  wire logic                    open_loop_i,
   input  wire logic [LEN_W-1:0]        len_i,
   input  wire logic signed [OFS_W-1:0] offset_i,
   input  wire logic [STEP_W-1:0]       step_i,
   output logic [MS_W-1:0]              ms_o,
   output logic                         ready_o
);

   // ********************************************************
   // adjusted length = (nominal + offset) steps, floored at 0
   // ********************************************************
   wire signed [LEN_W+1:0] len_s = signed'({2'b00, len_i});
   wire signed [LEN_W+1:0] ofs_s =
      {{(LEN_W+2-OFS_W){offset_i[OFS_W-1]}}, offset_i};
   wire signed [LEN_W+1:0] sum_s = len_s + ofs_s;
   wire [LEN_W:0] open_steps = (sum_s < 0) ? '0 : sum_s[LEN_W:0];
   wire [LEN_W:0] steps = open_loop_i ? open_steps
                                      : {1'b0, len_i};
   // ms = steps * step period, so in open loop the offset adds offset*step
   wire [MS_W-1:0] ms_next = MS_W'(steps) * MS_W'(step_i);

   // result register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_o    <= '0;
         ready_o <= 1'b0;
      end else begin
         ready_o <= valid_i;
         if (valid_i) begin
            ms_o <= ms_next;
         end
      end
   end

   a_closed_ignores: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (valid_i && !open_loop_i)
         |=> ms_o == MS_W'($past(len_i)) * MS_W'($past(step_i)))
      else $error("closed loop brake time used the offset");

   a_floor_zero: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (valid_i && open_loop_i && sum_s < 0) |=> ms_o == '0)
      else $error("negative brake time not floored at zero");

endmodule

// [haptic_brake_cal_regs.sv]
`timescale 1ns/1ps
module haptic_brake_cal_regs (
   input  wire logic                CORE_CLK_I,
   input  wire logic                RST_I,
   input  wire logic [7:0]          REG_ADDR_I,
   input  wire logic [7:0]          REG_WDATA_I,
   input  wire logic                REG_WR_I,
   input  wire logic                REG_RD_I,
   output logic [7:0]               REG_RDATA_O,
   input  wire logic                OPEN_LOOP_I,
   input  wire logic [7:0]          SAMPLE_STEP_PERIOD_I,
   input  wire logic                SCAN_VALID_I,
   input  wire logic                SCAN_FIRST_I,
   input  wire logic                SCAN_LAST_I,
   input  wire logic signed [7:0]   SCAN_SAMPLE_I,
   output logic signed [7:0]        BRAKE_LEVEL_O,
   output logic [16:0]              BRAKE_MS_O,
   output logic                     BRAKE_READY_O,
   input  wire logic [7:0]          DRIVE_REQ_I,
   input  wire logic                AUTO_OD_BRAKE_I,
   output logic [7:0]               DRIVE_LEVEL_O,
   input  wire logic                CAL_DONE_I,
   input  wire logic [7:0]          CAL_IMPEDANCE_I,
   input  wire logic [7:0]          CAL_FEEDBACK_I,
   output logic [7:0]               CAL_REF_LEVEL_O,
   output logic [7:0]               FEEDBACK_GAIN_O
);

   // ********************************************************
   // address decoding
   // ********************************************************

   // true when the bus address selects the given register
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   logic [7:0] brake_reg;
   logic [7:0] brake_next;
   logic [7:0] fs_reg;
   logic [7:0] fs_next;
   logic [7:0] od_reg;
   logic [7:0] od_next;
   logic [7:0] comp_reg;
   logic [7:0] comp_next;
   logic [7:0] fb_reg;
   logic [7:0] fb_next;
   logic [7:0] rdata_next;
   logic [7:0] drive_next;

   // write selects, one per register
   wire wr_brake = REG_WR_I & hit(REG_ADDR_I, brake_cal_pkg::OFS_BRAKE);
   wire wr_fs    = REG_WR_I & hit(REG_ADDR_I, brake_cal_pkg::OFS_FS);
   wire wr_od    = REG_WR_I & hit(REG_ADDR_I, brake_cal_pkg::OFS_OD);
   wire wr_comp  = REG_WR_I & hit(REG_ADDR_I, brake_cal_pkg::OFS_COMP);
   wire wr_fb    = REG_WR_I & hit(REG_ADDR_I, brake_cal_pkg::OFS_FB);

   // ********************************************************
   // calibration results
   // ********************************************************

   // loss compensation scales impedance by the rated level
   wire [15:0] comp_prod = 16'(CAL_IMPEDANCE_I) * 16'(fs_reg);
   wire [7:0]  comp_calc =
      8'(comp_prod >> brake_cal_pkg::COMP_SHIFT);

   // calibration update wins over a software write in the same cycle
   assign comp_next = CAL_DONE_I ? comp_calc :
                      wr_comp    ? REG_WDATA_I : comp_reg;
   assign fb_next   = CAL_DONE_I ? CAL_FEEDBACK_I :
                      wr_fb      ? REG_WDATA_I : fb_reg;

   // ********************************************************
   // software written parameters
   // ********************************************************
   assign brake_next = wr_brake ? REG_WDATA_I : brake_reg;
   assign fs_next    = wr_fs    ? REG_WDATA_I : fs_reg;
   assign od_next    = wr_od    ? REG_WDATA_I : od_reg;

   // parameter registers
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         brake_reg <= brake_cal_pkg::RST_BRAKE;
         fs_reg    <= brake_cal_pkg::RST_FS;
         od_reg    <= brake_cal_pkg::RST_OD;
      end else begin
         brake_reg <= brake_next;
         fs_reg    <= fs_next;
         od_reg    <= od_next;
      end
   end

   // calibration registers
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         comp_reg <= brake_cal_pkg::RST_COMP;
         fb_reg   <= brake_cal_pkg::RST_FB;
      end else begin
         comp_reg <= comp_next;
         fb_reg   <= fb_next;
      end
   end

   // ********************************************************
   // read path
   // ********************************************************

   // unmapped addresses and idle cycles read as zero
   assign rdata_next =
      !REG_RD_I ? brake_cal_pkg::RDATA_IDLE :
      hit(REG_ADDR_I, brake_cal_pkg::OFS_BRAKE) ? brake_reg :
      hit(REG_ADDR_I, brake_cal_pkg::OFS_FS)    ? fs_reg :
      hit(REG_ADDR_I, brake_cal_pkg::OFS_OD)    ? od_reg :
      hit(REG_ADDR_I, brake_cal_pkg::OFS_COMP)  ? comp_reg :
      hit(REG_ADDR_I, brake_cal_pkg::OFS_FB)    ? fb_reg :
      brake_cal_pkg::RDATA_IDLE;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         REG_RDATA_O <= brake_cal_pkg::RDATA_IDLE;
      end else begin
         REG_RDATA_O <= rdata_next;
      end
   end

   // ********************************************************
   // braking segment detection and timing
   // ********************************************************
   logic [7:0] brake_len;
   logic       seg_done;

   // finds the most negative level and its length in steps
   min_level_finder #(
      .SAMPLE_W (brake_cal_pkg::SAMPLE_W),
      .CNT_W    (brake_cal_pkg::LEN_W)
   ) u_finder (
      .clk_i    (CORE_CLK_I),
      .rst_i    (RST_I),
      .valid_i  (SCAN_VALID_I),
      .first_i  (SCAN_FIRST_I),
      .last_i   (SCAN_LAST_I),
      .sample_i (SCAN_SAMPLE_I),
      .min_o    (BRAKE_LEVEL_O),
      .len_o    (brake_len),
      .done_o   (seg_done)
   );

   // in open loop, stretches or shortens the segment by the signed offset
   brake_time_calc #(
      .LEN_W       (brake_cal_pkg::LEN_W),
      .OFS_W       (brake_cal_pkg::DATA_W),
      .STEP_W      (brake_cal_pkg::STEP_W)
   ) u_calc (
      .clk_i       (CORE_CLK_I),
      .rst_i       (RST_I),
      .valid_i     (seg_done),
      .open_loop_i (OPEN_LOOP_I),
      .len_i       (brake_len),
      .offset_i    (signed'(brake_reg)),
      .step_i      (SAMPLE_STEP_PERIOD_I),
      .ms_o        (BRAKE_MS_O),
      .ready_o     (BRAKE_READY_O)
   );

   // ********************************************************
   // closed-loop drive limiting
   // ********************************************************

   // overdrive and braking may exceed the rated level up to the clamp
   wire [7:0] drive_cap = AUTO_OD_BRAKE_I ? od_reg : fs_reg;
   assign drive_next = OPEN_LOOP_I ? DRIVE_REQ_I :
                       (DRIVE_REQ_I > drive_cap) ? drive_cap
                                                 : DRIVE_REQ_I;

   // drive level, calibration reference and feedback gain outputs
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         DRIVE_LEVEL_O   <= 8'h00;
         CAL_REF_LEVEL_O <= brake_cal_pkg::RST_FS;
         FEEDBACK_GAIN_O <= brake_cal_pkg::RST_FB;
      end else begin
         DRIVE_LEVEL_O   <= drive_next;
         CAL_REF_LEVEL_O <= fs_reg;
         FEEDBACK_GAIN_O <= fb_reg;
      end
   end

   // ********************************************************
   // checks
   // ********************************************************

   // a waveform ends; its brake time follows two cycles later
   sequence s_wave_end;
      SCAN_VALID_I && SCAN_LAST_I;
   endsequence

   sequence s_time_out;
      ##1 seg_done ##1 BRAKE_READY_O;
   endsequence

   property p_brake_latency;
      @(posedge CORE_CLK_I) disable iff (RST_I)
         s_wave_end |-> s_time_out;
   endproperty

   a_brake_latency: assert property (p_brake_latency)
      else $error("brake time not ready two cycles after waveform end");

   a_brake_write: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      wr_brake |=> brake_reg == $past(REG_WDATA_I))
      else $error("brake offset write lost");

   a_rdata_value: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && hit(REG_ADDR_I, brake_cal_pkg::OFS_FS))
         |=> REG_RDATA_O == $past(fs_reg))
      else $error("full-scale level read back wrong");

   a_rdata_idle: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      !REG_RD_I |=> REG_RDATA_O == brake_cal_pkg::RDATA_IDLE)
      else $error("read data not zero outside a read");

   a_closed_cap: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (!OPEN_LOOP_I && !AUTO_OD_BRAKE_I)
         |=> DRIVE_LEVEL_O <= $past(fs_reg)
             && (DRIVE_LEVEL_O == $past(DRIVE_REQ_I)
                 || DRIVE_LEVEL_O == $past(fs_reg)))
      else $error("closed loop drive exceeds full scale");

   a_overdrive_voltage_limit: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (!OPEN_LOOP_I && AUTO_OD_BRAKE_I && DRIVE_REQ_I > od_reg)
         |=> DRIVE_LEVEL_O == $past(od_reg))
      else $error("overdrive not limited to clamp");

   a_cal_store: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      CAL_DONE_I |=> comp_reg == $past(comp_calc)
                     && fb_reg == $past(CAL_FEEDBACK_I))
      else $error("calibration result not stored");

   a_gain_follow: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (wr_fb && !CAL_DONE_I) |=> ##1 FEEDBACK_GAIN_O == $past(REG_WDATA_I, 2))
      else $error("feedback gain does not follow feedback level");

   a_comp_impedance: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (CAL_DONE_I && CAL_IMPEDANCE_I == 8'h00) |=> comp_reg == 8'h00)
      else $error("loss compensation not derived from impedance");

   a_ref_level: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      wr_fs |=> ##1 CAL_REF_LEVEL_O == $past(REG_WDATA_I, 2))
      else $error("calibration reference not updated");

   // ********************************************************
   // register bus and drive level checks
   // ********************************************************

   a_fs_write: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      wr_fs |=> fs_reg == $past(REG_WDATA_I))
      else $error("full-scale level write lost");

   a_od_write: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      wr_od |=> od_reg == $past(REG_WDATA_I))
      else $error("overdrive limit write lost");

   a_comp_write: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (wr_comp && !CAL_DONE_I) |=> comp_reg == $past(REG_WDATA_I))
      else $error("loss compensation write lost");

   a_fb_write: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (wr_fb && !CAL_DONE_I) |=> fb_reg == $past(REG_WDATA_I))
      else $error("feedback level write lost");

   a_params_hold: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      !REG_WR_I |=> $stable(brake_reg) && $stable(fs_reg)
                    && $stable(od_reg))
      else $error("parameter register changed without a write");

   a_cal_hold: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (!CAL_DONE_I && !REG_WR_I)
         |=> $stable(comp_reg) && $stable(fb_reg))
      else $error("calibration register changed on its own");

   a_brake_read: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && hit(REG_ADDR_I, brake_cal_pkg::OFS_BRAKE))
         |=> REG_RDATA_O == $past(brake_reg))
      else $error("brake offset read back wrong");

   a_od_read: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && hit(REG_ADDR_I, brake_cal_pkg::OFS_OD))
         |=> REG_RDATA_O == $past(od_reg))
      else $error("overdrive limit read back wrong");

   a_comp_read: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && hit(REG_ADDR_I, brake_cal_pkg::OFS_COMP))
         |=> REG_RDATA_O == $past(comp_reg))
      else $error("loss compensation read back wrong");

   a_fb_read: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && hit(REG_ADDR_I, brake_cal_pkg::OFS_FB))
         |=> REG_RDATA_O == $past(fb_reg))
      else $error("feedback level read back wrong");

   a_unmapped_read: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (REG_RD_I && !hit(REG_ADDR_I, brake_cal_pkg::OFS_BRAKE)
       && !hit(REG_ADDR_I, brake_cal_pkg::OFS_FS)
       && !hit(REG_ADDR_I, brake_cal_pkg::OFS_OD)
       && !hit(REG_ADDR_I, brake_cal_pkg::OFS_COMP)
       && !hit(REG_ADDR_I, brake_cal_pkg::OFS_FB))
         |=> REG_RDATA_O == brake_cal_pkg::RDATA_IDLE)
      else $error("unmapped address did not read as zero");

   a_open_pass: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      OPEN_LOOP_I |=> DRIVE_LEVEL_O == $past(DRIVE_REQ_I))
      else $error("open loop drive request altered");

   a_od_bound: assert property (@(posedge CORE_CLK_I)
      disable iff (RST_I)
      (!OPEN_LOOP_I && AUTO_OD_BRAKE_I)
         |=> DRIVE_LEVEL_O <= $past(od_reg))
      else $error("overdrive drive above the limit");

endmodule

// [min_level_finder.sv]
`timescale 1ns/1ps
module min_level_finder #(
   parameter int SAMPLE_W = 8,
   parameter int CNT_W    = 8
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       valid_i,
   input  wire logic                       first_i,
   input  wire logic                       last_i,
   input  wire logic signed [SAMPLE_W-1:0] sample_i,
   output logic signed [SAMPLE_W-1:0]      min_o,
   output logic [CNT_W-1:0]                len_o,
   output logic                            done_o
);

   logic signed [SAMPLE_W-1:0] min_reg;
   logic signed [SAMPLE_W-1:0] min_next;
   logic [CNT_W-1:0]           cnt_reg;
   logic [CNT_W-1:0]           cnt_next;

   // ********************************************************
   // track most negative level and how many steps hold it
   // ********************************************************
   wire start    = valid_i & first_i;
   wire lower    = valid_i & ~first_i & (sample_i < min_reg);
   wire equal    = valid_i & ~first_i & (sample_i == min_reg);
   wire cnt_full = &cnt_reg;
   wire finish   = valid_i & last_i;

   assign min_next = (start | lower) ? sample_i : min_reg;
   assign cnt_next = (start | lower) ? CNT_W'(1) :
                     (equal & ~cnt_full) ? cnt_reg + CNT_W'(1) : cnt_reg;

   // running minimum
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         min_reg <= '0;
         cnt_reg <= '0;
      end else begin
         min_reg <= min_next;
         cnt_reg <= cnt_next;
      end
   end

   // publish the braking segment at the end of the waveform
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         min_o  <= '0;
         len_o  <= '0;
         done_o <= 1'b0;
      end else begin
         done_o <= finish;
         if (finish) begin
            min_o <= min_next;
            len_o <= cnt_next;
         end
      end
   end

   a_new_minimum: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (lower && !last_i) |=> (min_reg == $past(sample_i)) && (cnt_reg == 1))
      else $error("lower sample did not become the braking level");

endmodule

// [test_haptic_brake_cal_regs.sv]
`timescale 1ns/1ps
module test_haptic_brake_cal_regs;

   // ********************************************************
   // stimulus, observed outputs and bench model
   // ********************************************************
   logic              clk;
   logic              rst;
   logic              wr;
   logic              rd;
   logic              open_loop;
   logic              valid;
   logic              first;
   logic              last;
   logic              auto_od;
   logic              cal_done;
   logic [7:0]        addr;
   logic [7:0]        wdata;
   logic [7:0]        period;
   logic [7:0]        drive_req;
   logic [7:0]        cal_imp;
   logic [7:0]        cal_fb;
   logic signed [7:0] sample;
   logic [7:0]        rdata;
   logic [7:0]        drive_level;
   logic [7:0]        cal_ref;
   logic [7:0]        fb_gain;
   logic signed [7:0] brake_level;
   logic [16:0]       brake_ms;
   logic              brake_ready;
   int                mismatches;
   int                n_compared;
   logic [31:0]       seed;
   logic [7:0]        model [logic [7:0]];
   logic [7:0]        addrs [7];
   int                offsets [6];

   haptic_brake_cal_regs dut (
      .CORE_CLK_I           (clk),
      .RST_I                (rst),
      .REG_ADDR_I           (addr),
      .REG_WDATA_I          (wdata),
      .REG_WR_I             (wr),
      .REG_RD_I             (rd),
      .REG_RDATA_O          (rdata),
      .OPEN_LOOP_I          (open_loop),
      .SAMPLE_STEP_PERIOD_I (period),
      .SCAN_VALID_I         (valid),
      .SCAN_FIRST_I         (first),
      .SCAN_LAST_I          (last),
      .SCAN_SAMPLE_I        (sample),
      .BRAKE_LEVEL_O        (brake_level),
      .BRAKE_MS_O           (brake_ms),
      .BRAKE_READY_O        (brake_ready),
      .DRIVE_REQ_I          (drive_req),
      .AUTO_OD_BRAKE_I      (auto_od),
      .DRIVE_LEVEL_O        (drive_level),
      .CAL_DONE_I           (cal_done),
      .CAL_IMPEDANCE_I      (cal_imp),
      .CAL_FEEDBACK_I       (cal_fb),
      .CAL_REF_LEVEL_O      (cal_ref),
      .FEEDBACK_GAIN_O      (fb_gain)
   );

   // ********************************************************
   // clock, random source, comparisons
   // ********************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // xorshift keeps the run repeatable
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h",
                  $time, what, got, exp);
      end
   endtask

   task automatic chk_out(input logic [16:0] got, input logic [16:0] exp,
                          input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h",
                  $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ********************************************************
   // register bus tasks
   // ********************************************************
   // write is one strobe cycle; unmapped places are not modelled
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (model.exists(a)) model[a] = d;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_reg(rdata, model.exists(a) ? model[a] : 8'h00, "read data");
      @(posedge clk);
      #1;
      chk_reg(rdata, 8'h00, "idle read data");
   endtask

   // ********************************************************
   // waveform scan: random samples, model of minimum and length
   // ********************************************************
   task automatic scan(input int n);
      logic [31:0] t;
      int          v;
      int          mn;
      int          len;
      int          ofs;
      int          exp;
      mn  = 127;
      len = 0;
      for (int i = 0; i < n; i++) begin
         t = rnd();
         v = int'(t[2:0]) - 4;
         if (v < mn) begin
            mn  = v;
            len = 1;
         end else if (v == mn) begin
            len++;
         end
         @(posedge clk);
         valid  <= 1'b1;
         first  <= (i == 0);
         last   <= (i == n - 1);
         sample <= 8'(v);
      end
      @(posedge clk);
      valid <= 1'b0;
      first <= 1'b0;
      last  <= 1'b0;
      #1;
      chk_reg(brake_level, 8'(mn), "brake level");
      ofs = int'($signed(model[brake_cal_pkg::OFS_BRAKE]));
      exp = open_loop ? len + ofs : len;
      if (exp < 0) exp = 0;
      exp = exp * int'(period);
      @(posedge clk);
      #1;
      chk_out(17'(brake_ready), 17'h00001, "brake ready");
      chk_out(brake_ms, 17'(exp), "brake ms");
      @(posedge clk);
      #1;
      chk_out(17'(brake_ready), 17'h00000, "brake ready end");
   endtask

   // ********************************************************
   // watchdog
   // ********************************************************
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end

   // ********************************************************
   // main sequence
   // ********************************************************
   initial begin
      int          exp;
      logic [31:0] t;
      seed = 32'h00001BA4;
      {rst, wr, rd, open_loop, valid, first, last, auto_od, cal_done} = 9'h1FF;
      {wr, rd, valid, first, last, auto_od, cal_done} = 7'h00;
      {addr, wdata, period, drive_req, cal_imp, cal_fb} = 48'h0;
      sample = 8'h00;
      mismatches = 0;
      n_compared = 0;
      addrs = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23};
      offsets = '{0, 3, -1, -100, 127, -128};
      model[brake_cal_pkg::OFS_BRAKE] = brake_cal_pkg::RST_BRAKE;
      model[brake_cal_pkg::OFS_FS]    = brake_cal_pkg::RST_FS;
      model[brake_cal_pkg::OFS_OD]    = brake_cal_pkg::RST_OD;
      model[brake_cal_pkg::OFS_COMP]  = brake_cal_pkg::RST_COMP;
      model[brake_cal_pkg::OFS_FB]    = brake_cal_pkg::RST_FB;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk_reg(cal_ref, brake_cal_pkg::RST_FS, "reference level");
      chk_reg(fb_gain, brake_cal_pkg::RST_FB, "feedback gain");
      // reset values, unmapped places included
      foreach (addrs[i]) rd_chk(addrs[i]);
      // random write and read back, unmapped writes ignored
      repeat (3) begin
         foreach (addrs[i]) wr_reg(addrs[i], 8'(rnd()));
         foreach (addrs[i]) rd_chk(addrs[i]);
      end
      chk_reg(cal_ref, model[brake_cal_pkg::OFS_FS], "reference");
      // brake offsets in both loop modes, boundary values included
      for (int m = 0; m < 2; m++) begin
         foreach (offsets[i]) begin
            wr_reg(brake_cal_pkg::OFS_BRAKE, 8'(offsets[i]));
            t = rnd();
            @(posedge clk);
            open_loop <= (m == 0);
            period    <= t[7:0];
            scan(1 + int'(t[10:8]));
         end
      end
      // drive limiting against full-scale and overdrive limit
      repeat (16) begin
         t = rnd();
         @(posedge clk);
         open_loop <= t[8];
         auto_od   <= t[9];
         drive_req <= t[7:0];
         @(posedge clk);
         #1;
         if (open_loop) exp = int'(drive_req);
         else if (auto_od) exp = int'(model[brake_cal_pkg::OFS_OD]);
         else exp = int'(model[brake_cal_pkg::OFS_FS]);
         if (int'(drive_req) < exp) exp = int'(drive_req);
         chk_reg(drive_level, 8'(exp), "drive level");
      end
      // calibration results beat a same-cycle software write
      for (int k = 0; k < 3; k++) begin
         wr_reg(brake_cal_pkg::OFS_FS, 8'(rnd()));
         t = rnd();
         if (k == 0) t[7:0] = 8'h00;
         @(posedge clk);
         cal_imp  <= t[7:0];
         cal_fb   <= t[15:8];
         cal_done <= 1'b1;
         addr     <= brake_cal_pkg::OFS_FB;
         wdata    <= ~t[15:8];
         wr       <= 1'b1;
         @(posedge clk);
         cal_done <= 1'b0;
         wr       <= 1'b0;
         exp = (int'(t[7:0]) * int'(model[brake_cal_pkg::OFS_FS])) >> 8;
         model[brake_cal_pkg::OFS_COMP] = 8'(exp);
         model[brake_cal_pkg::OFS_FB]   = t[15:8];
         rd_chk(brake_cal_pkg::OFS_COMP);
         rd_chk(brake_cal_pkg::OFS_FB);
         chk_reg(fb_gain, t[15:8], "feedback gain");
      end
      end_of_test();
   end

endmodule
